/* sim/afh_hop_seq_sva.sv */
`timescale 1ns/1ps
module afh_hop_seq_sva
(
    input wire logic                      ref_clk,
    input wire logic                      rst_b,
    input wire logic                      hsel,
    input wire logic [31:0]               haddr,
    input wire logic [1:0]                htrans,
    input wire logic                      hwrite,
    input wire logic [31:0]               hwdata,
    input wire logic                      hready,
    input wire logic                      hreadyout,
    input wire logic                      hresp,
    input wire logic [afh_pkg::LVL_W-1:0] out_level,
    input wire logic [afh_pkg::FRQ_W-1:0] out_freq,
    input wire logic                      out_dc,
    input wire logic                      sync_out
);
    // ********
    // Register shadows
    // ********
    logic        a_wr, seen, cfg_ok;
    logic [11:0] a_ad;
    logic [6:0]  ctl;
    logic [31:0] car;
    logic [23:0] dwl;
    logic [15:0] dcl;
    logic [3:0]  age;
    logic [24:0] hold;
    assign cfg_ok = (age > 4'h3);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            a_wr <= 1'b0;
            a_ad <= 12'h000;
        end
        else if (hready)
        begin
            a_wr <= hsel && htrans[1] && hwrite;
            a_ad <= haddr[11:0];
        end
    end
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl <= afh_pkg::CTRL_RST;
            car <= afh_pkg::CARRIER_RST;
            dwl <= afh_pkg::DWELL_RST;
            dcl <= afh_pkg::DC_RST;
        end
        else if (a_wr && hready)
        begin
            if (a_ad == afh_pkg::REG_CTRL) ctl <= hwdata[6:0];
            if (a_ad == afh_pkg::REG_CARRIER) car <= hwdata;
            if (a_ad == afh_pkg::REG_DWELL) dwl <= hwdata[23:0];
            if (a_ad == afh_pkg::REG_DC) dcl <= hwdata[15:0];
        end
    end
    // Settling age and hold length of the frequency output
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            age  <= 4'h0;
            hold <= 25'h0;
            seen <= 1'b0;
        end
        else
        begin
            age  <= (a_wr && hready) ? 4'h0 : ((age == 4'hf) ? age : age + 4'h1);
            hold <= $changed(out_freq) ? 25'h1 : hold + 25'h1;
            seen <= (a_wr && hready) ? 1'b0 : (seen || $changed(out_freq));
        end
    end
    // ********
    // Properties
    // ********
    sequence s_fixed_run;
        ctl[1] && !ctl[2] && ctl[6:5] == 2'h0 && seen;
    endsequence
    sequence s_step;
        out_freq != $past(out_freq);
    endsequence
    property p_fixed_hold;
        s_fixed_run ##0 s_step |-> hold == {1'b0, ((dwl == 24'h0) ? 24'h1 : dwl)};
    endproperty
    AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
    AST_SYNC_ONE: assert property (sync_out |=> !sync_out) else $error("sync pulse too long");
    AST_SYNC_GATED: assert property (cfg_ok && !ctl[3] |-> !sync_out) else $error("sync while off");
    AST_CARRIER: assert property (cfg_ok && !ctl[1] |-> out_freq == car) else $error("freq not carrier");
    AST_DC_LEVEL: assert property (cfg_ok && out_dc |-> out_level == dcl) else $error("dc level wrong");
    AST_DC_MODE: assert property (cfg_ok && ctl[6:5] == 2'h0 |-> !out_dc) else $error("dc idle in cont");
    AST_CW_IDLE: assert property (cfg_ok && ctl[4] |-> !out_dc) else $error("dc idle with cw");
    AST_FIXED_HOLD: assert property (p_fixed_hold) else $error("fixed dwell length wrong");
endmodule

bind afh_hop_seq afh_hop_seq_sva i_sva
(
    .ref_clk,
    .rst_b,
    .hsel,
    .haddr,
    .htrans,
    .hwrite,
    .hwdata,
    .hready,
    .hreadyout,
    .hresp,
    .out_level,
    .out_freq,
    .out_dc,
    .sync_out
);

/* sim/test_amplitude_frequency_hop_sequencer.sv */
`timescale 1ns/1ps
module test_amplitude_frequency_hop_sequencer;
    logic        ref_clk, rst_b, hsel, hwrite, trig_in, hreadyout, hresp, out_dc, sync_out, sel_amp;
    logic [31:0] haddr, hwdata, hrdata, out_freq, rd, obs;
    logic [31:0] ev [4];
    logic [31:0] fq [4];
    logic [15:0] lv [4];
    logic [15:0] out_level;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          err_total, n_checks, cyc, nsync, n;
    int          ed [4];
    assign obs = sel_amp ? {16'h0, out_level} : out_freq;
    afh_hop_seq i_dut
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .trig_in(trig_in),
        .out_level(out_level),
        .out_freq(out_freq),
        .out_dc(out_dc),
        .sync_out(sync_out)
    );
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (sync_out === 1'b1) nsync++;
        if (cyc == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end
    // ********
    // Tasks
    // ********
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk_val(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task chk_cyc(input int g, input int e);
        n_checks++;
        if (g != e)
        begin
            err_total++;
            $display("FAIL t=%0t cycles %h exp %h", $time, g, e);
        end
    endtask
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk_val(rd, e);
    endtask
    task wait_val(input logic [31:0] v);
        n = 0;
        while (obs !== v && n < 300)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask
    // Follows the steps, checking each value and the hold of the one before
    task run_seq(input int cnt);
        for (int i = 0; i < cnt; i++)
        begin
            wait_val(ev[i % 4]);
            chk_val(obs, ev[i % 4]);
            if (i > 0) chk_cyc(n, ed[(i - 1) % 4]);
        end
    endtask
    task pulse;
        trig_in <= 1'b1;
        repeat (3) @(posedge ref_clk);
        trig_in <= 1'b0;
    endtask
    // ********
    // Sequence
    // ********
    initial
    begin
        {rst_b, hsel, hwrite, trig_in, sel_amp, htrans, hsize, haddr, hwdata} = '0;
        err_total = 0;
        n_checks = 0;
        cyc = 0;
        nsync = 0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk_val({out_dc, sync_out, hresp, hreadyout}, 32'h1);
        rchk(afh_pkg::REG_CTRL, 32'h0);
        rchk(afh_pkg::REG_DWELL, 32'h1);
        rchk(afh_pkg::REG_DC, 32'h0);
        ahb(1'b1, 12'h040, 32'hffff_ffff);
        rchk(12'h040, 32'h0);
        ahb(1'b1, afh_pkg::REG_CARRIER, 32'h1234_5678);
        ahb(1'b1, afh_pkg::REG_DWELL, 32'h5);
        ahb(1'b1, afh_pkg::REG_LENGTH, 32'h3);
        ahb(1'b1, afh_pkg::REG_MARKER, 32'h2);
        ahb(1'b1, afh_pkg::REG_DC, 32'h0abc);
        for (int i = 0; i < 4; i++)
        begin
            fq[i] = 32'h0100_0011 * (i + 1);
            lv[i] = 16'h0111 * (i + 1);
            ahb(1'b1, afh_pkg::TBL_FRQ_BASE + 12'(4 * i), fq[i]);
            ahb(1'b1, afh_pkg::TBL_LVL_BASE + 12'(4 * i), {16'h0, lv[i]});
            ahb(1'b1, afh_pkg::TBL_DWL_BASE + 12'(4 * i), 32'(3 + 2 * i));
        end
        rchk(afh_pkg::REG_CARRIER, 32'h1234_5678);
        chk_val(out_freq, 32'h1234_5678);
        for (int i = 0; i < 4; i++)
        begin
            ev[i] = fq[i];
            ed[i] = 5;
        end
        nsync = 0;
        ahb(1'b1, afh_pkg::REG_CTRL, 32'h0a);
        #1;
        run_seq(5);
        chk_cyc(nsync, 1);
        chk_val(out_level, 16'hffff);
        ahb(1'b1, afh_pkg::REG_CTRL, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            ev[i] = {16'h0, lv[i]};
            ed[i] = 3 + 2 * i;
        end
        sel_amp = 1'b1;
        nsync = 0;
        ahb(1'b1, afh_pkg::REG_CTRL, 32'h05);
        #1;
        run_seq(5);
        chk_cyc(nsync, 0);
        chk_val(out_freq, 32'h1234_5678);
        ahb(1'b1, afh_pkg::REG_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) ed[i] = 5;
        ahb(1'b1, afh_pkg::REG_CTRL, 32'h21);
        repeat (40) @(posedge ref_clk);
        #1;
        chk_val({out_dc, out_level}, 32'h1_0abc);
        pulse();
        #1;
        run_seq(4);
        wait_val(32'h0abc);
        chk_cyc(n, 5);
        chk_val(out_dc, 1'b1);
        ahb(1'b1, afh_pkg::REG_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) ev[i] = fq[i];
        sel_amp = 1'b0;
        ahb(1'b1, afh_pkg::REG_CTRL, 32'h52);
        repeat (40) @(posedge ref_clk);
        #1;
        chk_val(out_freq, 32'h1234_5678);
        chk_val(out_dc, 1'b0);
        for (int t = 0; t < 2; t++)
        begin
            if (t == 0) ahb(1'b1, afh_pkg::REG_TRIG, 32'h1);
            else pulse();
            #1;
            run_seq(4);
            wait_val(32'h1234_5678);
            chk_cyc(n, 5);
        end
        give_verdict();
    end
endmodule

/* verilog/afh_dwell_timer.sv */
`timescale 1ns/1ps
// Counts down a dwell; done pulses when the count expires.
module afh_dwell_timer
(
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    input  wire logic                      load,
    input  wire logic [afh_pkg::DWL_W-1:0] load_val,
    input  wire logic                      run,
    output logic                           done
);

    logic [afh_pkg::DWL_W-1:0] count;

    // Last cycle of the dwell, so the reload lands on the expiring edge
    assign done = run && (count == afh_pkg::DWL_W'(1));

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count <= '0;
        end
        else if (load)
        begin
            // Zero dwell treated as one cycle
            count <= (load_val == '0) ? afh_pkg::DWL_W'(1) : load_val;
        end
        else if (run && count != '0)
        begin
            count <= count - afh_pkg::DWL_W'(1);
        end
    end

endmodule

/* verilog/afh_hop_seq.sv */
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
//
// Function
// RQ1: Separate enables for amplitude hop and frequency hop; hop only when enabled.
// RQ2: Fixed mode holds every entry for one programmed dwell time.
// RQ3: Variable mode holds each entry for the dwell stored with it.
// RQ4: Global dwell used only in fixed mode, ignored in variable mode.
// RQ5: Amplitude hop applies table levels to output, one per step, in order.
// RQ6: Frequency hop steps through table frequencies in written order.
// RQ7: Sync pulse when sequencer reaches the marker index step.
// RQ8: No marker pulse unless sync output enable is set.
// RQ9: Baseline CW or DC chooses idle output in triggered or burst modes.
// RQ10: DC baseline idles at DC level, hops only after accepted trigger.
// RQ11: CW baseline idles on carrier, hops per trigger, then returns to carrier.
// RQ12: Carrier register is unmodulated output frequency before hopping.
// RQ13: Continuous mode wraps from last entry to first while enabled.
//
module afh_hop_seq
(
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic [31:0]                    hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire logic                      trig_in,
    output logic [afh_pkg::LVL_W-1:0]      out_level,
    output logic [afh_pkg::FRQ_W-1:0]      out_freq,
    output logic                           out_dc,
    output logic                           sync_out
);

    // ****************************************
    // Storage
    // ****************************************
    logic [6:0]                  ctrl;
    logic [afh_pkg::FRQ_W-1:0]   carrier;
    logic [afh_pkg::DWL_W-1:0]   dwell;
    logic [afh_pkg::IDX_W-1:0]   marker;
    logic [afh_pkg::IDX_W-1:0]   last_idx;
    logic [afh_pkg::LVL_W-1:0]   dc_level;
    logic [afh_pkg::LVL_W-1:0]   lvl_tbl [afh_pkg::TBL_DEPTH];
    logic [afh_pkg::FRQ_W-1:0]   frq_tbl [afh_pkg::TBL_DEPTH];
    logic [afh_pkg::DWL_W-1:0]   dwl_tbl [afh_pkg::TBL_DEPTH];
    logic                        sw_trig;
    logic [afh_pkg::IDX_W-1:0]   idx;
    afh_pkg::afh_state_t         state;

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    logic                        ap_wr;
    logic                        ap_rd;
    logic [afh_pkg::ADDR_W-1:0]  ap_addr;
    logic [afh_pkg::ADDR_W-1:0]  tbl_sel;
    logic [afh_pkg::IDX_W-1:0]   tbl_idx;
    logic                        hop_on;
    logic                        hw_trig;
    afh_pkg::afh_run_t           run_mode;

    assign tbl_sel  = ap_addr & afh_pkg::TBL_MASK;
    assign tbl_idx  = ap_addr[afh_pkg::IDX_W+1:2];
    assign hop_on   = ctrl[afh_pkg::CTRL_AMP_EN] | ctrl[afh_pkg::CTRL_FRQ_EN];
    assign run_mode = afh_pkg::afh_run_t'(ctrl[afh_pkg::CTRL_RUN_HI:afh_pkg::CTRL_RUN_LO]);

    // Registered address phase, zero wait state
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ap_wr   <= 1'b0;
            ap_rd   <= 1'b0;
            ap_addr <= '0;
        end
        else if (hready)
        begin
            ap_wr   <= hsel && htrans[1] && hwrite;
            ap_rd   <= hsel && htrans[1] && !hwrite;
            ap_addr <= haddr[afh_pkg::ADDR_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl     <= afh_pkg::CTRL_RST;
            carrier  <= afh_pkg::CARRIER_RST;
            dwell    <= afh_pkg::DWELL_RST;
            marker   <= '0;
            last_idx <= '0;
            dc_level <= afh_pkg::DC_RST;
            sw_trig  <= 1'b0;
        end
        else
        begin
            sw_trig <= 1'b0;
            if (ap_wr)
            begin
                if (ap_addr == afh_pkg::REG_CTRL)
                begin
                    ctrl <= hwdata[6:0];
                end
                else if (ap_addr == afh_pkg::REG_CARRIER)
                begin
                    carrier <= hwdata;
                end
                else if (ap_addr == afh_pkg::REG_DWELL)
                begin
                    dwell <= hwdata[afh_pkg::DWL_W-1:0];
                end
                else if (ap_addr == afh_pkg::REG_MARKER)
                begin
                    marker <= hwdata[afh_pkg::IDX_W-1:0];
                end
                else if (ap_addr == afh_pkg::REG_LENGTH)
                begin
                    last_idx <= hwdata[afh_pkg::IDX_W-1:0];
                end
                else if (ap_addr == afh_pkg::REG_TRIG)
                begin
                    sw_trig <= hwdata[0];
                end
                else if (ap_addr == afh_pkg::REG_DC)
                begin
                    dc_level <= hwdata[afh_pkg::LVL_W-1:0];
                end
            end
        end
    end

    // Hop tables, one entry per word
    always_ff @(posedge ref_clk)
    begin
        if (ap_wr && tbl_sel == afh_pkg::TBL_LVL_BASE)
        begin
            lvl_tbl[tbl_idx] <= hwdata[afh_pkg::LVL_W-1:0];
        end
        if (ap_wr && tbl_sel == afh_pkg::TBL_FRQ_BASE)
        begin
            frq_tbl[tbl_idx] <= hwdata;
        end
        if (ap_wr && tbl_sel == afh_pkg::TBL_DWL_BASE)
        begin
            dwl_tbl[tbl_idx] <= hwdata[afh_pkg::DWL_W-1:0];
        end
    end

    // Read data
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hrdata <= '0;
        end
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            if (haddr[afh_pkg::ADDR_W-1:0] == afh_pkg::REG_CTRL)
            begin
                hrdata <= {25'h0, ctrl};
            end
            else if (haddr[afh_pkg::ADDR_W-1:0] == afh_pkg::REG_CARRIER)
            begin
                hrdata <= carrier;
            end
            else if (haddr[afh_pkg::ADDR_W-1:0] == afh_pkg::REG_DWELL)
            begin
                hrdata <= {8'h0, dwell};
            end
            else if (haddr[afh_pkg::ADDR_W-1:0] == afh_pkg::REG_MARKER)
            begin
                hrdata <= {28'h0, marker};
            end
            else if (haddr[afh_pkg::ADDR_W-1:0] == afh_pkg::REG_LENGTH)
            begin
                hrdata <= {28'h0, last_idx};
            end
            else if (haddr[afh_pkg::ADDR_W-1:0] == afh_pkg::REG_STATUS)
            begin
                hrdata <= {25'h0, state, idx};
            end
            else if (haddr[afh_pkg::ADDR_W-1:0] == afh_pkg::REG_DC)
            begin
                hrdata <= {16'h0, dc_level};
            end
            else
            begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // ****************************************
    // Trigger and dwell
    // ****************************************
    logic                        ext_trig;
    logic                        dwl_load;
    logic                        dwl_done;
    logic [afh_pkg::DWL_W-1:0]   dwl_val;
    logic [afh_pkg::IDX_W-1:0]   next_idx;
    logic [afh_pkg::IDX_W-1:0]   load_idx;

    afh_trig_sync u_trig
    (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .pin     (trig_in),
        .rise    (ext_trig)
    );

    assign hw_trig  = ext_trig | sw_trig;
    assign next_idx = (idx == last_idx) ? '0 : idx + afh_pkg::IDX_W'(1);
    assign load_idx = (state == afh_pkg::ST_IDLE) ? '0 : next_idx;
    // Per-step dwell in variable mode, global otherwise
    assign dwl_val  = ctrl[afh_pkg::CTRL_VAR_DWL] ? dwl_tbl[load_idx] : dwell; // RQ3 RQ4
    assign dwl_load = (state == afh_pkg::ST_IDLE && hop_on
                       && (run_mode == afh_pkg::RUN_CONT || hw_trig))
                      || (state == afh_pkg::ST_HOP && dwl_done
                          && (idx != last_idx || run_mode == afh_pkg::RUN_CONT));

    afh_dwell_timer u_dwell
    (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .load     (dwl_load),
        .load_val (dwl_val),
        .run      (state == afh_pkg::ST_HOP),
        .done     (dwl_done)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= afh_pkg::ST_IDLE;
            idx   <= '0;
        end
        else if (!hop_on)
        begin
            state <= afh_pkg::ST_IDLE; // RQ1
            idx   <= '0;
        end
        else
        begin
            case (state)
                afh_pkg::ST_IDLE:
                begin
                    if (dwl_load)
                    begin
                        state <= afh_pkg::ST_HOP; // RQ10 RQ11
                        idx   <= '0;
                    end
                end
                afh_pkg::ST_HOP:
                begin
                    if (dwl_done)
                    begin
                        if (idx == last_idx && run_mode != afh_pkg::RUN_CONT)
                        begin
                            state <= afh_pkg::ST_IDLE; // RQ11
                        end
                        else
                        begin
                            idx <= next_idx; // RQ2 RQ6 RQ13
                        end
                    end
                end
                default:
                begin
                    state <= afh_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic hopping;
    logic idle_dc;

    assign hopping = (state == afh_pkg::ST_HOP);
    assign idle_dc = !hopping && hop_on && run_mode != afh_pkg::RUN_CONT
                     && !ctrl[afh_pkg::CTRL_BASE_CW]; // RQ9

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_level <= '0;
            out_freq  <= '0;
            out_dc    <= 1'b0;
            sync_out  <= 1'b0;
        end
        else
        begin
            out_dc   <= idle_dc; // RQ10
            out_freq <= (hopping && ctrl[afh_pkg::CTRL_FRQ_EN]) ? frq_tbl[idx] : carrier; // RQ6 RQ12
            if (idle_dc)
            begin
                out_level <= dc_level;
            end
            else if (hopping && ctrl[afh_pkg::CTRL_AMP_EN])
            begin
                out_level <= lvl_tbl[idx]; // RQ5
            end
            else
            begin
                out_level <= '1;
            end
            // One pulse per arrival at the marker step
            sync_out <= ctrl[afh_pkg::CTRL_SYNC_EN] && dwl_load && (load_idx == marker); // RQ7 RQ8
        end
    end

endmodule

/* verilog/afh_pkg.sv */
package afh_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int TBL_DEPTH = 16;
    localparam int IDX_W     = 4;
    localparam int LVL_W     = 16;
    localparam int FRQ_W     = 32;
    localparam int DWL_W     = 24;
    localparam int ADDR_W    = 12;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [ADDR_W-1:0] REG_CTRL    = 12'h000;
    localparam logic [ADDR_W-1:0] REG_CARRIER = 12'h004;
    localparam logic [ADDR_W-1:0] REG_DWELL   = 12'h008;
    localparam logic [ADDR_W-1:0] REG_MARKER  = 12'h00c;
    localparam logic [ADDR_W-1:0] REG_LENGTH  = 12'h010;
    localparam logic [ADDR_W-1:0] REG_TRIG    = 12'h014;
    localparam logic [ADDR_W-1:0] REG_STATUS  = 12'h018;
    localparam logic [ADDR_W-1:0] REG_DC      = 12'h01c;
    localparam logic [ADDR_W-1:0] TBL_LVL_BASE = 12'h100;
    localparam logic [ADDR_W-1:0] TBL_FRQ_BASE = 12'h200;
    localparam logic [ADDR_W-1:0] TBL_DWL_BASE = 12'h300;
    localparam logic [ADDR_W-1:0] TBL_MASK     = 12'hf00;

    // ****************************************
    // Control fields
    // ****************************************
    localparam int CTRL_AMP_EN   = 0;
    localparam int CTRL_FRQ_EN   = 1;
    localparam int CTRL_VAR_DWL  = 2;
    localparam int CTRL_SYNC_EN  = 3;
    localparam int CTRL_BASE_CW  = 4;
    localparam int CTRL_RUN_LO   = 5;
    localparam int CTRL_RUN_HI   = 6;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [6:0]       CTRL_RST    = 7'h00;
    localparam logic [FRQ_W-1:0] CARRIER_RST = 32'h0000_0000;
    localparam logic [DWL_W-1:0] DWELL_RST   = 24'h00_0001;
    localparam logic [LVL_W-1:0] DC_RST      = 16'h0000;

    // ****************************************
    // Run modes and states
    // ****************************************
    typedef enum logic [1:0] {
        RUN_CONT  = 2'h0,
        RUN_TRIG  = 2'h1,
        RUN_BURST = 2'h2
    } afh_run_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOP  = 3'b010,
        ST_WAIT = 3'b100
    } afh_state_t;

endpackage

/* verilog/afh_trig_sync.sv */
`timescale 1ns/1ps
// Three-stage input sync; one pulse per accepted rising edge.
module afh_trig_sync
(
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic pin,
    output logic      rise
);

    logic s1;
    logic s2;
    logic s3;
    logic level;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
            rise  <= 1'b0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            rise <= (s2 == s3) && s3 && !level;
            if (s2 == s3)
            begin
                level <= s3;
            end
        end
    end

endmodule
